/* hdl/twm_pkg.sv */
// Constants and types shared by the two-wire master control block
package twm_pkg;
	// ------------------------------------------------
	// Register offsets and reset value
	// ------------------------------------------------
	localparam logic [3:0] OFF_DBG = 4'h2;
	localparam logic [3:0] OFF_CTLA = 4'h3;
	localparam logic [3:0] OFF_CTLB = 4'h4;
	localparam logic [3:0] OFF_STAT = 4'h5;
	localparam logic [3:0] OFF_BAUD = 4'h6;
	localparam logic [3:0] OFF_ADDR = 4'h7;
	localparam logic [3:0] OFF_DATA = 4'h8;
	localparam logic [7:0] REG_RST = 8'h00;

	// ------------------------------------------------
	// Field positions
	// ------------------------------------------------
	localparam int DB_RUN = 0;
	localparam int CA_EN = 0;
	localparam int CA_SMART = 1;
	localparam int CA_TOUT = 2;
	localparam int CA_QUICK = 4;
	localparam int CA_WRITE_IRQ_ENABLE = 6;
	localparam int CA_READ_IRQ_ENABLE = 7;
	localparam int CB_CMD = 0;
	localparam int CB_ACK = 2;
	localparam int CB_FLUSH = 3;
	localparam int SB_ARB = 3;
	localparam int SB_WIF = 6;
	localparam int SB_RIF = 7;

	// ------------------------------------------------
	// Codes
	// ------------------------------------------------
	localparam logic [1:0] CMD_RESERVED = 2'h0;
	localparam logic [1:0] CMD_RESTART = 2'h1;
	localparam logic [1:0] CMD_XFER = 2'h2;
	localparam logic [1:0] CMD_STOP = 2'h3;
	localparam logic [1:0] LS_UNKNOWN = 2'h0;
	localparam logic [1:0] LS_IDLE = 2'h1;
	localparam logic [1:0] LS_OWNER = 2'h2;
	localparam logic [1:0] LS_BUSY = 2'h3;
	localparam logic [1:0] TOUT_OFF = 2'h0;
	localparam logic ACK_NACK = 1'b1;

	// ------------------------------------------------
	// Timing
	// ------------------------------------------------
	localparam int CLK_HZ = 100_000_000;
	localparam int CYC_PER_US = CLK_HZ / 1_000_000;
	localparam int TOUT1_US = 50;
	localparam int TOUT2_US = 100;
	localparam int TOUT3_US = 200;
	localparam int TOUT1_CYC = TOUT1_US * CYC_PER_US;
	localparam int TOUT2_CYC = TOUT2_US * CYC_PER_US;
	localparam int TOUT3_CYC = TOUT3_US * CYC_PER_US;
	localparam int TOUT_W = 16;
	localparam int HALF_MIN_CYC = 5;

	// ------------------------------------------------
	// Types
	// ------------------------------------------------
	typedef enum logic [2:0] {
		S_IDLE = 3'b000, S_START = 3'b001, S_LOW = 3'b011, S_HIGH = 3'b010,
		S_HOLD = 3'b110, S_STOP = 3'b111, S_RSTART = 3'b101
	} twm_state_e;
	typedef enum logic [1:0] {M_TX = 2'h0, M_RX = 2'h1, M_ACK = 2'h2} twm_mode_e;
	typedef enum logic [1:0] {
		OP_NONE = 2'h0, OP_READ = 2'h1, OP_RESTART = 2'h2, OP_STOP = 2'h3
	} twm_op_e;
endpackage

/* hdl/twm_sync.sv */
`timescale 1ns/10ps
// Two-flop synchroniser for the bus lines
module twm_sync #(
	parameter int W = 2
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] meta_r;

	// -----------------------------
	// Stages; idle bus reads high
	// -----------------------------
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			meta_r <= '1;
			sync_out <= '1;
		end else begin
			meta_r <= async_in;
			sync_out <= meta_r;
		end
	end
endmodule

/* hdl/twm_timeout.sv */
`timescale 1ns/10ps
// Inactive bus supervisor: counts quiet cycles, pulses on expiry
module twm_timeout
	import twm_pkg::*;
#(
	parameter int C1 = TOUT1_CYC,
	parameter int C2 = TOUT2_CYC,
	parameter int C3 = TOUT3_CYC
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic run,
	input wire logic [1:0] sel,
	input wire logic activity,
	output logic expire
);
	// Counter must hold the longest period
	if (C1 >= (1 << TOUT_W) || C2 >= (1 << TOUT_W) || C3 >= (1 << TOUT_W) ||
		C1 < 1 || C2 < 1 || C3 < 1) begin : g_chk
		$error("twm_timeout: period out of range");
	end

	logic [TOUT_W-1:0] cnt_r;
	wire [TOUT_W-1:0] limit = (sel == 2'h1) ? TOUT_W'(C1) :
		(sel == 2'h2) ? TOUT_W'(C2) : TOUT_W'(C3);
	wire armed = run && (sel != TOUT_OFF) && !activity;
	wire hit = armed && (cnt_r == limit);

	// -----------------------------
	// Quiet counter, restarts on any edge
	// -----------------------------
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			cnt_r <= '0;
			expire <= 1'b0;
		end else begin
			cnt_r <= (armed && !hit) ? cnt_r + 1'b1 : '0;
			expire <= hit;
		end
	end
endmodule

/* hdl/twm_master.sv */
`timescale 1ns/10ps
// Register front end and bit engine of the two-wire master

module twm_master
	import twm_pkg::*;
#(
	parameter int TOUT1_CYC_P = TOUT1_CYC,
	parameter int TOUT2_CYC_P = TOUT2_CYC,
	parameter int TOUT3_CYC_P = TOUT3_CYC
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic cpu_halted,
	input wire logic global_irq_en,
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	output logic read_irq,
	output logic write_irq
);
	// ------------------------------------------------
	// Helpers
	// ------------------------------------------------
	function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
		hit = (a == off);
	endfunction

	// Next state once an ack bit or a command has been dealt with
	function automatic twm_state_e go(input twm_op_e op);
		case (op)
			OP_READ: go = S_LOW;
			OP_RESTART: go = S_RSTART;
			OP_STOP: go = S_STOP;
			default: go = S_HOLD;
		endcase
	endfunction

	// ------------------------------------------------
	// Storage
	// ------------------------------------------------
	logic [1:0] line_s;
	logic scl_p_r, sda_p_r;
	logic run_r, ack_r;
	logic [7:0] ctla_r, baud_r, addr_r;
	logic rd_flag_r, wr_flag_r, arb_r, received_ack_bit_r;
	logic [1:0] line_r, line_nxt;
	twm_state_e st_r, st_nxt;
	twm_mode_e mode_r, mode_nxt;
	twm_op_e op_r, op_nxt;
	logic [3:0] bit_r, bit_nxt;
	logic half_r, half_nxt;
	logic [7:0] sh_r, sh_nxt;
	logic aph_r, aph_nxt;
	logic ackp_r, ackp_nxt;
	logic received_ack_bit_nxt;
	logic sreq_r;
	logic [8:0] div_r;
	logic rd_set, wr_set, arb_set;
	logic sda_d_r;
	logic tout_exp;
	twm_op_e cmd_op;

	// ------------------------------------------------
	// Line inputs
	// ------------------------------------------------
	twm_sync #(.W(2)) u_sync (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.async_in({scl_in, sda_in}),
		.sync_out(line_s)
	);
	wire scl_s = line_s[1];
	wire sda_s = line_s[0];

	// ------------------------------------------------
	// Decode and qualified events
	// ------------------------------------------------
	// debug halt gate
	wire live = !(cpu_halted && !run_r);
	wire en = ctla_r[CA_EN];
	wire wr_dbg = reg_wr && hit(reg_addr, OFF_DBG);
	wire wr_ctla = reg_wr && hit(reg_addr, OFF_CTLA);
	wire wr_ctlb = reg_wr && hit(reg_addr, OFF_CTLB);
	wire wr_stat = reg_wr && hit(reg_addr, OFF_STAT);
	wire wr_baud = reg_wr && hit(reg_addr, OFF_BAUD);
	wire wr_addr = reg_wr && hit(reg_addr, OFF_ADDR);
	wire wr_data = reg_wr && hit(reg_addr, OFF_DATA);
	wire rd_data = reg_rd && hit(reg_addr, OFF_DATA);
	wire in_hold = (st_r == S_HOLD);
	wire dir_rd = addr_r[0];
	// one-cycle flush strobe, write 0 ignored
	wire flush = wr_ctlb && live && reg_wdata[CB_FLUSH];
	wire kill = !en || flush || tout_exp;
	// command field write is a strobe
	wire [1:0] cmd = reg_wdata[CB_CMD +: 2];
	wire do_cmd = wr_ctlb && live && en && in_hold && (cmd != CMD_RESERVED);
	wire do_addr = wr_addr && live && en;
	// data write never takes the ack path
	wire do_wdata = wr_data && live && en && in_hold;
	// smart mode acts on a data read
	wire do_smart = rd_data && live && en && in_hold && ctla_r[CA_SMART] && ackp_r;
	// shared clear sources for the done flags
	wire clr_any = live && (wr_addr || wr_data || rd_data || wr_ctlb);
	wire rd_clr = clr_any || (wr_stat && reg_wdata[SB_RIF]);
	wire wr_clr = clr_any || (wr_stat && reg_wdata[SB_WIF]);
	wire arb_clr = clr_any || (wr_stat && reg_wdata[SB_ARB]);

	// ------------------------------------------------
	// Bit timing
	// ------------------------------------------------
	// Clock held off while a slave stretches the high phase
	wire [8:0] half_c = 9'(HALF_MIN_CYC) + {1'b0, baud_r};
	wire stall = (st_r == S_IDLE) || in_hold || ((st_r == S_HIGH) && !scl_s);
	wire tick = !stall && (div_r >= half_c);
	wire tx_bit = (mode_r == M_TX) && !bit_r[3];
	wire drv_low = tx_bit ? !sh_r[7] : ((mode_r == M_ACK) && !ack_r);
	wire tx_one = (tx_bit && sh_r[7]) || ((mode_r == M_ACK) && ack_r);

	// ------------------------------------------------
	// Command decoding
	// ------------------------------------------------
	// restart or stop follow the ack; code 2 by direction
	always_comb begin
		case (cmd)
			CMD_RESTART: cmd_op = OP_RESTART;
			CMD_STOP: cmd_op = OP_STOP;
			default: cmd_op = dir_rd ? OP_READ : OP_NONE;
		endcase
	end

	// ------------------------------------------------
	// Engine next state
	// ------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		mode_nxt = mode_r;
		op_nxt = op_r;
		bit_nxt = bit_r;
		half_nxt = half_r;
		sh_nxt = sh_r;
		aph_nxt = aph_r;
		ackp_nxt = ackp_r;
		received_ack_bit_nxt = received_ack_bit_r;
		rd_set = 1'b0;
		wr_set = 1'b0;
		arb_set = 1'b0;
		case (st_r)
			S_IDLE: begin
				if (sreq_r && line_r == LS_IDLE) begin
					st_nxt = S_START;
				end
			end
			S_START: begin
				if (tick) begin
					st_nxt = S_LOW;
					sh_nxt = addr_r;
					mode_nxt = M_TX;
					bit_nxt = 4'h0;
					aph_nxt = 1'b1;
				end
			end
			S_LOW: begin
				if (tick) begin
					st_nxt = S_HIGH;
				end
			end
			S_HIGH: begin
				if (tick && tx_one && !sda_s) begin
					// Lost arbitration: a transmitted byte still reports as done with the
					// write flag despite the loss; a lost ack bit sets no write flag
					arb_set = 1'b1;
					wr_set = (mode_r == M_TX);
					st_nxt = S_IDLE;
					ackp_nxt = 1'b0;
				end else if (tick) begin
					case (mode_r)
						M_TX: begin
							if (!bit_r[3]) begin
								sh_nxt = {sh_r[6:0], sda_s};
								bit_nxt = bit_r + 4'h1;
								st_nxt = S_LOW;
							end else begin
								received_ack_bit_nxt = sda_s;
								aph_nxt = 1'b0;
								if (aph_r && !sda_s && dir_rd && !ctla_r[CA_QUICK]) begin
									mode_nxt = M_RX;
									bit_nxt = 4'h0;
									st_nxt = S_LOW;
								end else begin
									rd_set = aph_r && !sda_s && dir_rd;
									wr_set = !(aph_r && !sda_s && dir_rd);
									st_nxt = S_HOLD;
								end
							end
						end
						M_RX: begin
							sh_nxt = {sh_r[6:0], sda_s};
							if (bit_r == 4'h7) begin
								rd_set = 1'b1;
								ackp_nxt = 1'b1;
								st_nxt = S_HOLD;
							end else begin
								bit_nxt = bit_r + 4'h1;
								st_nxt = S_LOW;
							end
						end
						default: begin
							ackp_nxt = 1'b0;
							st_nxt = go(op_r);
							mode_nxt = M_RX;
							bit_nxt = 4'h0;
						end
					endcase
				end
			end
			S_RSTART, S_STOP: begin
				if (tick) begin
					half_nxt = !half_r;
					if (half_r) begin
						st_nxt = (st_r == S_STOP) ? S_IDLE : S_START;
					end
				end
			end
			S_HOLD: begin
				if (do_addr) begin
					st_nxt = S_RSTART;
					half_nxt = 1'b0;
					ackp_nxt = 1'b0;
				end else if (do_wdata) begin
					// transmit straight away, no ack bit
					// a pending byte write starts here
					sh_nxt = reg_wdata;
					mode_nxt = M_TX;
					bit_nxt = 4'h0;
					aph_nxt = 1'b0;
					st_nxt = S_LOW;
				end else if (do_smart) begin
					// send the stored choice, read on if ACK
					mode_nxt = M_ACK;
					bit_nxt = 4'h8;
					op_nxt = (ack_r == ACK_NACK) ? OP_NONE : OP_READ;
					st_nxt = S_LOW;
				end else if (do_cmd && ackp_r) begin
					// ack action on command, new choice used
					mode_nxt = M_ACK;
					bit_nxt = 4'h8;
					op_nxt = cmd_op;
					st_nxt = S_LOW;
				end else if (do_cmd) begin
					// write direction waits for a data write
					st_nxt = go(cmd_op);
					half_nxt = 1'b0;
					mode_nxt = M_RX;
					bit_nxt = 4'h0;
				end
			end
			default: st_nxt = S_IDLE;
		endcase
	end

	// ------------------------------------------------
	// Engine registers
	// ------------------------------------------------
	// frozen while halted unless the run bit is set; dropped on disable, flush or time-out
	always_ff @(posedge sys_clk) begin
		if (!rst_n || kill) begin
			st_r <= S_IDLE;
			mode_r <= M_TX;
			op_r <= OP_NONE;
			bit_r <= 4'h0;
			half_r <= 1'b0;
			aph_r <= 1'b0;
			ackp_r <= 1'b0;
			div_r <= 9'h000;
		end else if (live) begin
			st_r <= st_nxt;
			mode_r <= mode_nxt;
			op_r <= op_nxt;
			bit_r <= bit_nxt;
			half_r <= half_nxt;
			aph_r <= aph_nxt;
			ackp_r <= ackp_nxt;
			div_r <= (stall || tick) ? 9'h000 : div_r + 9'h001;
		end
	end

	// Shift data survives a flush so software can still read it
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			sh_r <= REG_RST;
			received_ack_bit_r <= 1'b0;
		end else if (live) begin
			sh_r <= sh_nxt;
			received_ack_bit_r <= received_ack_bit_nxt;
		end
	end

	// Start request waits for an idle line
	always_ff @(posedge sys_clk) begin
		if (!rst_n || kill) begin
			sreq_r <= 1'b0;
		end else if (do_addr && !in_hold) begin
			sreq_r <= 1'b1;
		end else if (st_r == S_START) begin
			sreq_r <= 1'b0;
		end
	end

	// ------------------------------------------------
	// Line drivers
	// ------------------------------------------------
	// Data line lags the clock by a cycle for hold time
	wire scl_c = (st_r == S_LOW) || in_hold ||
		(((st_r == S_RSTART) || (st_r == S_STOP)) && !half_r);
	wire sda_c = (st_r == S_START) || (st_r == S_STOP) ||
		(((st_r == S_LOW) || (st_r == S_HIGH)) && drv_low);

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			scl_oe <= 1'b0;
			sda_d_r <= 1'b0;
			sda_oe <= 1'b0;
		end else begin
			scl_oe <= scl_c;
			sda_d_r <= sda_c;
			sda_oe <= sda_d_r;
		end
	end
	assign scl_out = 1'b0;
	assign sda_out = 1'b0;

	// ------------------------------------------------
	// Line state monitor
	// ------------------------------------------------
	wire start_seen = scl_s && scl_p_r && sda_p_r && !sda_s;
	wire stop_seen = scl_s && scl_p_r && !sda_p_r && sda_s;
	wire activity = (scl_s != scl_p_r) || (sda_s != sda_p_r);

	always_comb begin
		line_nxt = line_r;
		if (!en) begin
			line_nxt = LS_UNKNOWN;
		end else if (flush || tout_exp) begin
			line_nxt = LS_IDLE;
		end else if (arb_set) begin
			line_nxt = LS_BUSY;
		end else if (st_r == S_START) begin
			line_nxt = LS_OWNER;
		end else if (stop_seen) begin
			line_nxt = LS_IDLE;
		end else if (start_seen) begin
			line_nxt = LS_BUSY;
		end else if (wr_stat && reg_wdata[1:0] == LS_IDLE) begin
			line_nxt = LS_IDLE;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			scl_p_r <= 1'b1;
			sda_p_r <= 1'b1;
			line_r <= LS_UNKNOWN;
		end else begin
			scl_p_r <= scl_s;
			sda_p_r <= sda_s;
			line_r <= line_nxt;
		end
	end

	// period selected by the time-out field
	twm_timeout #(
		.C1(TOUT1_CYC_P),
		.C2(TOUT2_CYC_P),
		.C3(TOUT3_CYC_P)
	) u_tout (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.run(en && live && line_r != LS_IDLE),
		.sel(ctla_r[CA_TOUT +: 2]),
		.activity(activity),
		.expire(tout_exp)
	);

	// ------------------------------------------------
	// Software registers
	// ------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			run_r <= 1'b0;
			ctla_r <= REG_RST;
			ack_r <= 1'b0;
			baud_r <= REG_RST;
			addr_r <= REG_RST;
		end else begin
			run_r <= wr_dbg ? reg_wdata[DB_RUN] : run_r;
			ctla_r <= wr_ctla ? (reg_wdata & 8'hDF) : ctla_r;
			ack_r <= wr_ctlb ? reg_wdata[CB_ACK] : ack_r;
			baud_r <= wr_baud ? reg_wdata : baud_r;
			addr_r <= wr_addr ? reg_wdata : addr_r;
		end
	end

	// Status flags: a set in the clearing cycle wins
	// read, write and arbitration flag set and clear
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			rd_flag_r <= 1'b0;
			wr_flag_r <= 1'b0;
			arb_r <= 1'b0;
		end else begin
			rd_flag_r <= (rd_set && live) || (rd_flag_r && !rd_clr);
			wr_flag_r <= (wr_set && live) || (wr_flag_r && !wr_clr);
			arb_r <= (arb_set && live) || (arb_r && !arb_clr);
		end
	end

	// ------------------------------------------------
	// Read back and interrupt requests
	// ------------------------------------------------
	// command and flush bits read as zero
	wire [7:0] stat_v = {rd_flag_r, wr_flag_r, in_hold, received_ack_bit_r, arb_r, 1'b0, line_r};
	wire [7:0] rd_mux =
		hit(reg_addr, OFF_DBG) ? {7'h00, run_r} :
		hit(reg_addr, OFF_CTLA) ? ctla_r :
		hit(reg_addr, OFF_CTLB) ? {5'h00, ack_r, 2'h0} :
		hit(reg_addr, OFF_STAT) ? stat_v :
		hit(reg_addr, OFF_BAUD) ? baud_r :
		hit(reg_addr, OFF_ADDR) ? addr_r :
		hit(reg_addr, OFF_DATA) ? sh_r : 8'h00;

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			reg_rdata <= REG_RST;
		end else begin
			reg_rdata <= reg_rd ? rd_mux : REG_RST;
		end
	end

	// read request gated by both enables
	assign read_irq = rd_flag_r && ctla_r[CA_READ_IRQ_ENABLE] && global_irq_en;
	// write request gated by both enables
	assign write_irq = wr_flag_r && ctla_r[CA_WRITE_IRQ_ENABLE] && global_irq_en;
endmodule

/* verification/twm_master_monitor.sv */
// Port checker for the two-wire master
`timescale 1ns/10ps
module twm_monitor
	import twm_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic cpu_halted,
	input wire logic global_irq_en,
	input wire logic scl_oe,
	input wire logic sda_oe,
	input wire logic read_irq,
	input wire logic write_irq
);
	// ------
	// Shadow settings
	// ------
	logic [7:0] ctla_r;
	logic run_r;
	// Frozen engine ignores side effects, so clears only count when running
	wire frz = cpu_halted & !run_r;
	wire hit_b = reg_addr == OFF_CTLB;
	wire clr = !frz && ((reg_wr && (reg_addr == OFF_ADDR || reg_addr == OFF_DATA || hit_b))
		|| (reg_rd && reg_addr == OFF_DATA));
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			ctla_r <= REG_RST;
			run_r <= 1'b0;
		end else if (reg_wr && reg_addr == OFF_CTLA) begin
			ctla_r <= reg_wdata;
		end else if (reg_wr && reg_addr == OFF_DBG) begin
			run_r <= reg_wdata[DB_RUN];
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// ------
	// Assertions
	// ------
	rd_irq_gate_a: assert property (read_irq |-> global_irq_en && ctla_r[CA_READ_IRQ_ENABLE])
		else $error("read irq without its enables");
	wr_irq_gate_a: assert property (write_irq |-> global_irq_en && ctla_r[CA_WRITE_IRQ_ENABLE])
		else $error("write irq without its enables");
	flag_clear_a: assert property (clr |=> !read_irq && !write_irq)
		else $error("flag survived a clearing access");
	// Data line trails the clock line by a cycle, so look three cycles back
	off_released_a: assert property (!ctla_r[CA_EN] && !$past(ctla_r[CA_EN]) &&
		!$past(ctla_r[CA_EN], 2) && !$past(ctla_r[CA_EN], 3) && !cpu_halted
		|-> !scl_oe && !sda_oe)
		else $error("disabled master drives a line");
	halt_hold_a: assert property (frz && $past(frz) && $past(frz, 2) && $past(frz, 3)
		|-> $stable(scl_oe) && $stable(sda_oe))
		else $error("lines moved while halted");
	// Ack choice in bit 2 reads back; flush and command bits read zero
	cmd_zero_a: assert property (reg_rd && hit_b |=> {reg_rdata[3], reg_rdata[1:0]} == 3'h0)
		else $error("strobe fields read nonzero");
	rdata_quiet_a: assert property (!reg_rd |=> reg_rdata == REG_RST)
		else $error("read data outside read cycle");
	flush_free_a: assert property (reg_wr && hit_b && reg_wdata[CB_FLUSH] && !frz
		|-> ##[1:3] !scl_oe && !sda_oe)
		else $error("flush left a line driven");
endmodule
bind twm_master twm_monitor u_mon (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.cpu_halted(cpu_halted), .global_irq_en(global_irq_en), .scl_oe(scl_oe),
	.sda_oe(sda_oe), .read_irq(read_irq), .write_irq(write_irq));

/* verification/twm_slave.sv */
// Behavioural slave on the two-wire bus
`timescale 1ns/10ps
module twm_slave #(
	parameter logic [6:0] DEV_ADDR = 7'h50,
	parameter logic [7:0] RD_BYTE = 8'hC5
) (
	input wire logic scl,
	input wire logic sda,
	input wire logic slow,
	output logic scl_pull,
	output logic sda_pull,
	output logic [7:0] got_byte,
	output logic got_nack
);
	logic started = 1'b0;
	logic [7:0] b;
	// Data edge with clock high is start or stop: abandon the transfer
	always @(sda) begin
		if (scl === 1'b1) begin
			started = !sda;
			sda_pull = 1'b0;
			disable body;
		end
	end
	// ------
	// Byte tasks
	// ------
	task automatic rx8();
		repeat (8) begin
			@(posedge scl);
			b = {b[6:0], sda};
		end
		@(negedge scl);
	endtask
	// Slow mode stretches the clock low during the ack bit
	task automatic ack();
		sda_pull = 1'b1;
		if (slow) begin
			scl_pull = 1'b1;
			#2000;
			scl_pull = 1'b0;
		end
		@(posedge scl);
		@(negedge scl);
		sda_pull = 1'b0;
	endtask
	task automatic tx8();
		for (int i = 7; i >= 0; i--) begin
			sda_pull = !RD_BYTE[i];
			@(posedge scl);
			@(negedge scl);
		end
		sda_pull = 1'b0;
	endtask
	// Address, then bytes out until NACK or bytes in until stop
	initial begin
		scl_pull = 1'b0;
		sda_pull = 1'b0;
		got_byte = 8'h00;
		got_nack = 1'b0;
		forever begin : body
			wait (started);
			started = 1'b0;
			rx8();
			if (b[7:1] === DEV_ADDR) begin
				ack();
				got_nack = 1'b0;
				while (b[0] && !got_nack) begin
					tx8();
					@(posedge scl) got_nack = sda;
					@(negedge scl);
				end
				while (!b[0]) begin
					rx8();
					got_byte = b;
					ack();
				end
			end
		end
	end
endmodule

/* verification/twm_master_tb.sv */
// Bench for the two-wire master with a slave on the lines
`timescale 1ns/10ps
module twm_master_tb
	import twm_pkg::*;
();
	localparam int TMO[4] = '{300, 50, 100, 200};
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic cpu_halted = 1'b0;
	logic global_irq_en = 1'b0;
	logic slow = 1'b0;
	logic tb_pull = 1'b0;
	logic [7:0] reg_rdata, got_byte, v, ns;
	logic scl_oe, sda_oe, read_irq, write_irq, s_scl, s_sda, got_nack;
	int err_total = 0;
	int n_compared = 0;
	int n_start = 0;
	int cyc = 0;
	// Open-drain lines with pull-ups
	wire scl_w = !(scl_oe | s_scl);
	wire sda_w = !(sda_oe | s_sda | tb_pull);
	twm_master #(.TOUT1_CYC_P(TMO[1]), .TOUT2_CYC_P(TMO[2]), .TOUT3_CYC_P(TMO[3])) dut (
		.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_halted(cpu_halted),
		.global_irq_en(global_irq_en), .scl_in(scl_w), .scl_out(), .scl_oe(scl_oe),
		.sda_in(sda_w), .sda_out(), .sda_oe(sda_oe), .read_irq(read_irq),
		.write_irq(write_irq));
	twm_slave slv (.scl(scl_w), .sda(sda_w), .slow(slow), .scl_pull(s_scl), .sda_pull(s_sda),
		.got_byte(got_byte), .got_nack(got_nack));
	always #5 sys_clk = !sys_clk;
	// Start conditions seen on the wire
	always @(negedge sda_w) begin
		if (scl_w === 1'b1) n_start++;
	end
	// Hang guard
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 40000) begin
			err_total++;
			print_verdict();
		end
	end
	// ------
	// Tasks
	// ------
	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		n_compared++;
		if (g !== e) begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic look(input logic [3:0] a);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		look(a);
		chk(v, e);
	endtask
	// Poll a status flag under a bound
	task automatic wait_st(input int p);
		v = 8'h00;
		for (int k = 0; k < 300 && !v[p]; k++) look(OFF_STAT);
		chk({7'h0, v[p]}, 8'h01);
	endtask
	task automatic end_xfer(input logic [7:0] c);
		wr(OFF_CTLB, c);
		repeat (100) @(posedge sys_clk);
		rd(OFF_STAT, 8'h01);
	endtask
	// ------
	// Sequence
	// ------
	initial begin
		repeat (8) @(posedge sys_clk);
		rst_n <= 1'b1;
		for (int a = 2; a < 6; a++) rd(4'(a), REG_RST);
		wr(4'hF, 8'hFF);
		rd(4'hF, 8'h00);
		// Another party holds data low; supervisor code decides release
		for (int k = 0; k < 4; k++) begin
			@(posedge sys_clk) tb_pull <= 1'b0;
			wr(OFF_CTLA, {4'h0, 2'(k), 2'b01});
			@(posedge sys_clk) tb_pull <= 1'b1;
			repeat (TMO[k] - 20) @(posedge sys_clk);
			rd(OFF_STAT, 8'h03);
			repeat (40) @(posedge sys_clk);
			rd(OFF_STAT, (k == 0) ? 8'h03 : 8'h01);
		end
		@(posedge sys_clk) tb_pull <= 1'b0;
		wr(OFF_CTLA, 8'hFF);
		rd(OFF_CTLA, 8'hDF);
		// Address then byte write, slave stretching
		wr(OFF_CTLA, 8'hC1);
		@(posedge sys_clk) global_irq_en <= 1'b1;
		wr(OFF_ADDR, 8'hA0);
		wait_st(SB_WIF);
		chk({7'h0, write_irq}, 8'h01);
		rd(OFF_STAT, 8'h62);
		wr(OFF_CTLB, {6'h0, CMD_XFER});
		repeat (100) @(posedge sys_clk);
		chk({7'h0, scl_oe}, 8'h01);
		@(posedge sys_clk) slow <= 1'b1;
		wr(OFF_DATA, 8'h3C);
		wait_st(SB_WIF);
		chk(got_byte, 8'h3C);
		@(posedge sys_clk) slow <= 1'b0;
		end_xfer({6'h0, CMD_STOP});
		chk({6'h0, scl_w, sda_w}, 8'h03);
		// Smart read: data read sends ACK, then NACK with stop in one write
		wr(OFF_CTLA, 8'hC3);
		wr(OFF_ADDR, 8'hA1);
		wait_st(SB_RIF);
		chk({7'h0, read_irq}, 8'h01);
		rd(OFF_DATA, 8'hC5);
		chk({7'h0, read_irq}, 8'h00);
		wait_st(SB_RIF);
		end_xfer({5'h0, ACK_NACK, CMD_STOP});
		chk({7'h0, got_nack}, 8'h01);
		rd(OFF_CTLB, 8'h04);
		// Reserved code, restart, flush in mid-address
		wr(OFF_CTLA, 8'hC1);
		wr(OFF_ADDR, 8'hA0);
		wait_st(SB_WIF);
		wr(OFF_CTLB, {6'h0, CMD_RESERVED});
		rd(OFF_STAT, 8'h22);
		ns = n_start[7:0];
		wr(OFF_CTLB, {6'h0, CMD_RESTART});
		repeat (50) @(posedge sys_clk);
		chk(n_start[7:0], ns + 8'h01);
		wr(OFF_CTLB, 8'h08);
		rd(OFF_STAT, 8'h01);
		chk({6'h0, scl_w, sda_w}, 8'h03);
		// Debug halt in mid-address: lines frozen, then running by choice
		wr(OFF_ADDR, 8'hA0);
		repeat (40) @(posedge sys_clk);
		@(posedge sys_clk) cpu_halted <= 1'b1;
		// Let the line drivers settle before taking the snapshot
		repeat (3) @(posedge sys_clk);
		ns = n_start[7:0];
		v = {6'h0, scl_w, sda_w};
		wr(OFF_ADDR, 8'hA0);
		repeat (200) @(posedge sys_clk);
		chk(n_start[7:0], ns);
		chk({6'h0, scl_w, sda_w}, v);
		wr(OFF_DBG, 8'h01);
		rd(OFF_DBG, 8'h01);
		wait_st(SB_WIF);
		end_xfer({6'h0, CMD_STOP});
		@(posedge sys_clk) cpu_halted <= 1'b0;
		// Quick command in both directions
		wr(OFF_CTLA, 8'hD1);
		for (int d = 0; d < 2; d++) begin
			wr(OFF_ADDR, {7'h50, d[0]});
			wait_st(d ? SB_RIF : SB_WIF);
			end_xfer({6'h0, CMD_STOP});
		end
		// Master dropped in mid-address releases both lines
		wr(OFF_ADDR, 8'hA0);
		repeat (40) @(posedge sys_clk);
		wr(OFF_CTLA, 8'hC0);
		rd(OFF_STAT, 8'h00);
		chk({6'h0, scl_w, sda_w}, 8'h03);
		print_verdict();
	end
endmodule
